/* hdl/cbe_params.svh */
`ifndef CBE_PARAMS_SVH
`define CBE_PARAMS_SVH

// ==========================================================
// opcodes of the branch group
`define CBE_OP_CARRY_SET      8'h25
`define CBE_OP_EQUAL          8'h27
`define CBE_OP_SIGNED_GE      8'h90
`define CBE_OP_SIGNED_GT      8'h92
`define CBE_OP_HALF_CLEAR     8'h28
`define CBE_OP_HALF_SET       8'h29
`define CBE_OP_UNSIGNED_HI    8'h22
`define CBE_OP_UNSIGNED_HS    8'h24

// ==========================================================
// condition code bit positions
`define CBE_CCR_C             0
`define CBE_CCR_Z             1
`define CBE_CCR_N             2
`define CBE_CCR_H             4
`define CBE_CCR_V             7

// ==========================================================
// timing and instruction length
`define CBE_INSTR_LEN         16'h0002
`define CBE_EXEC_CYCLES       3

// ==========================================================
// register port map
`define CBE_REG_CTRL          4'h0
`define CBE_REG_STATUS        4'h1
`define CBE_REG_TAKEN_CNT     4'h2
`define CBE_REG_SKIP_CNT      4'h3
`define CBE_CTRL_RESET        8'h01
`define CBE_CTRL_EN_BIT       0
`define CBE_CTRL_CLR_BIT      1
`define CBE_STAT_BUSY_BIT     0
`define CBE_STAT_LAST_BIT     1
`define CBE_STAT_REFUSED_BIT  2
`define CBE_BYTE_ZERO         8'h00
`define CBE_CNT_ONE           8'h01

`endif

/* hdl/cbe_pkg.sv */
package cbe_pkg;
	// ==========================================================
	// shared types
	typedef logic [7:0] cbe_byte_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN1,
		ST_RUN2,
		ST_RUN3
	} cbe_state_t;
endpackage

/* hdl/cbe_cond_decode.sv */
`timescale 1ns/1ps
`include "cbe_params.svh"

// ==========================================================
// opcode decode and flag test, purely combinational
module cbe_cond_decode
	import cbe_pkg::*;
(
	input  wire cbe_byte_t opcode,
	input  wire cbe_byte_t condition_code_register,
	output logic           in_group,
	output logic           cond_true
);
	// membership test, drives in_group only; cond_true decodes the opcode by its own case
	function automatic logic is_member(input cbe_byte_t op);
		unique case (op)
			`CBE_OP_CARRY_SET, `CBE_OP_EQUAL, `CBE_OP_SIGNED_GE,
			`CBE_OP_SIGNED_GT, `CBE_OP_HALF_CLEAR, `CBE_OP_HALF_SET,
			`CBE_OP_UNSIGNED_HI, `CBE_OP_UNSIGNED_HS: is_member = 1'b1;
			default: is_member = 1'b0;
		endcase
	endfunction

	logic c_f, z_f, n_f, h_f, v_f;   // named flags
	logic sgn_lt;                     // signed less-than term

	always_comb begin
		c_f = condition_code_register[`CBE_CCR_C];
		z_f = condition_code_register[`CBE_CCR_Z];
		n_f = condition_code_register[`CBE_CCR_N];
		h_f = condition_code_register[`CBE_CCR_H];
		v_f = condition_code_register[`CBE_CCR_V];
		sgn_lt = n_f ^ v_f;
		in_group = is_member(opcode);
		// unknown opcodes never report a true condition
		unique case (opcode)
			`CBE_OP_CARRY_SET:   cond_true = c_f;
			`CBE_OP_EQUAL:       cond_true = z_f;
			`CBE_OP_SIGNED_GE:   cond_true = ~sgn_lt;
			`CBE_OP_SIGNED_GT:   cond_true = ~(z_f | sgn_lt);
			`CBE_OP_HALF_CLEAR:  cond_true = ~h_f;
			`CBE_OP_HALF_SET:    cond_true = h_f;
			`CBE_OP_UNSIGNED_HI: cond_true = ~c_f & ~z_f;
			`CBE_OP_UNSIGNED_HS: cond_true = ~c_f;
			default:             cond_true = 1'b0;
		endcase
	end
endmodule

/* hdl/cbe_target_adder.sv */
`timescale 1ns/1ps
`include "cbe_params.svh"

// ==========================================================
// taken target and fall-through address
module cbe_target_adder
	import cbe_pkg::*;
#(
	parameter int PC_W = 16
) (
	input  wire logic [PC_W-1:0] pc,
	input  wire cbe_byte_t       offset,
	output logic      [PC_W-1:0] target,
	output logic      [PC_W-1:0] fall_thru
);
	logic [PC_W-1:0] ofs_ext;   // offset sign-extended to pc width
	logic [PC_W-1:0] pc_plus;   // address after the instruction

	always_comb begin
		ofs_ext   = {{(PC_W-8){offset[7]}}, offset};
		pc_plus   = pc + PC_W'(`CBE_INSTR_LEN);
		// wrap at the top of the address space is intended
		target    = pc_plus + ofs_ext;
		fall_thru = pc_plus;
	end
endmodule

/* hdl/cbe_branch_unit.sv */
`timescale 1ns/1ps
`include "cbe_params.svh"

module cbe_branch_unit
	import cbe_pkg::*;
#(
	parameter int PC_W = 16
) (
	input  wire logic            core_clk,
	input  wire logic            reset_n,
	input  wire logic            clk_en,
	input  wire logic            issue_valid,
	input  wire cbe_byte_t       issue_opcode,
	input  wire cbe_byte_t       issue_offset,
	input  wire logic [PC_W-1:0] issue_pc,
	input  wire cbe_byte_t       ccr_in,
	output logic                 issue_ready,
	output logic                 done,
	output logic                 branch_taken,
	output logic      [PC_W-1:0] pc_next,
	output cbe_byte_t            ccr_out,
	output logic                 refused,
	input  wire logic [3:0]      reg_addr,
	input  wire cbe_byte_t       reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output cbe_byte_t            reg_rdata
);
	// ==========================================================
	// elaboration checks
	initial begin
		if (PC_W < 8 || PC_W > 32)
			$error("cbe_branch_unit: PC_W must lie in 8..32");
	end

	// ==========================================================
	// declarations
	cbe_state_t      state_reg, state_next;   // execution sequencer
	cbe_byte_t       op_cap_reg;              // opcode under execution
	cbe_byte_t       ofs_cap_reg;             // offset byte under execution
	cbe_byte_t       ccr_cap_reg;             // flags seen at issue
	logic [PC_W-1:0] pc_cap_reg;              // pc of the branch opcode
	logic            issue_ready_reg;         // issue slot free
	logic            done_reg;                // one-cycle completion pulse
	logic            taken_reg;               // outcome of last branch
	logic [PC_W-1:0] pc_next_reg;             // resolved next pc
	cbe_byte_t       ccr_out_reg;             // flags handed back unchanged
	logic            refused_reg;             // refusal flag, high each cycle an offer is not taken
	cbe_byte_t       ctrl_reg;                // control register
	logic            refused_sticky_reg;      // sticky refusal status
	cbe_byte_t       taken_cnt_reg;           // taken branch counter
	cbe_byte_t       skip_cnt_reg;            // not-taken branch counter
	cbe_byte_t       reg_rdata_reg;           // read data, one cycle late
	logic            in_group_w;              // incoming opcode is ours
	logic            cond_w;                  // condition of captured op
	logic [PC_W-1:0] target_w;                // taken target
	logic [PC_W-1:0] fall_w;                  // fall-through address
	logic            unit_en;                 // software enable
	logic            accept;                  // issue taken this edge
	logic            retire;                  // last execution cycle
	logic            clr_cnt;                 // counter clear strobe
	logic            stat_clr;                // write-one clear of sticky

	assign unit_en  = ctrl_reg[`CBE_CTRL_EN_BIT];
	assign accept   = clk_en & issue_valid & issue_ready_reg & unit_en & in_group_w;
	assign retire   = clk_en & (state_reg == ST_RUN3);
	assign clr_cnt  = clk_en & reg_wr & (reg_addr == `CBE_REG_CTRL)
	                  & reg_wdata[`CBE_CTRL_CLR_BIT];
	assign stat_clr = clk_en & reg_wr & (reg_addr == `CBE_REG_STATUS)
	                  & reg_wdata[`CBE_STAT_REFUSED_BIT];

	// ==========================================================
	// leaf instances
	// membership of the opcode offered on the issue port
	cbe_cond_decode u_issue_dec (
		.opcode    (issue_opcode),
		.condition_code_register       (ccr_in),
		.in_group  (in_group_w),
		.cond_true ()
	);

	// flag test on the captured opcode and flags
	cbe_cond_decode u_exec_dec (
		.opcode    (op_cap_reg),
		.condition_code_register       (ccr_cap_reg),
		.in_group  (),
		.cond_true (cond_w)
	);

	cbe_target_adder #(
		.PC_W      (PC_W)
	) u_adder (
		.pc        (pc_cap_reg),
		.offset    (ofs_cap_reg),
		.target    (target_w),
		.fall_thru (fall_w)
	);

	// ==========================================================
	// sequencer: three cycles per branch, next issue overlaps retire
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (accept) state_next = ST_RUN1;
			ST_RUN1: state_next = ST_RUN2;           // offset byte cycle
			ST_RUN2: state_next = ST_RUN3;
			ST_RUN3: state_next = accept ? ST_RUN1 : ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// ready is registered, so it looks one state ahead; a take in the
	// retire cycle is the earliest that leaves the captured operands intact
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			issue_ready_reg <= 1'b1;
		end else if (clk_en) begin
			issue_ready_reg <= (state_next == ST_IDLE) || (state_next == ST_RUN3);
		end
	end

	// ==========================================================
	// operand capture at issue
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			op_cap_reg  <= `CBE_BYTE_ZERO;
			ofs_cap_reg <= `CBE_BYTE_ZERO;
			ccr_cap_reg <= `CBE_BYTE_ZERO;
			pc_cap_reg  <= '0;
		end else if (accept) begin
			op_cap_reg  <= issue_opcode;
			ofs_cap_reg <= issue_offset;
			ccr_cap_reg <= ccr_in;
			pc_cap_reg  <= issue_pc;
		end
	end

	// ==========================================================
	// result: next pc, outcome, and the flags returned untouched
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			done_reg    <= 1'b0;
			taken_reg   <= 1'b0;
			pc_next_reg <= '0;
			ccr_out_reg <= `CBE_BYTE_ZERO;
		end else if (clk_en) begin
			done_reg <= retire;
			if (retire) begin
				taken_reg   <= cond_w;
				// taken loads target, else step past both bytes
				pc_next_reg <= cond_w ? target_w : fall_w;
				// no write path to flags exists; copy what came in
				ccr_out_reg <= ccr_cap_reg;
			end
		end
	end

	// ==========================================================
	// refusal: busy, disabled, or opcode outside the group
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			refused_reg <= 1'b0;
		end else if (clk_en) begin
			refused_reg <= issue_valid & ~accept;
		end
	end

	// sticky copy; a new refusal beats a clear in the same cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			refused_sticky_reg <= 1'b0;
		end else if (clk_en) begin
			if (issue_valid & ~accept)
				refused_sticky_reg <= 1'b1;
			else if (stat_clr)
				refused_sticky_reg <= 1'b0;
		end
	end

	// ==========================================================
	// control register; the clear bit is a strobe and reads zero
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= `CBE_CTRL_RESET;
		end else if (clk_en && reg_wr && reg_addr == `CBE_REG_CTRL) begin
			ctrl_reg <= reg_wdata & `CBE_CTRL_RESET;
		end
	end

	// outcome counters; a retire in the clear cycle still counts
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			taken_cnt_reg <= `CBE_BYTE_ZERO;
			skip_cnt_reg  <= `CBE_BYTE_ZERO;
		end else if (clk_en) begin
			if (clr_cnt) begin
				taken_cnt_reg <= (retire & cond_w)  ? `CBE_CNT_ONE : `CBE_BYTE_ZERO;
				skip_cnt_reg  <= (retire & ~cond_w) ? `CBE_CNT_ONE : `CBE_BYTE_ZERO;
			end else if (retire) begin
				if (cond_w)
					taken_cnt_reg <= taken_cnt_reg + `CBE_CNT_ONE;
				else
					skip_cnt_reg  <= skip_cnt_reg + `CBE_CNT_ONE;
			end
		end
	end

	// ==========================================================
	// read port; unmapped offsets read zero
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_reg <= `CBE_BYTE_ZERO;
		end else if (clk_en) begin
			reg_rdata_reg <= `CBE_BYTE_ZERO;
			if (reg_rd) begin
				unique case (reg_addr)
					`CBE_REG_CTRL:      reg_rdata_reg <= ctrl_reg;
					`CBE_REG_STATUS: begin
						reg_rdata_reg[`CBE_STAT_BUSY_BIT]    <= state_reg != ST_IDLE;
						reg_rdata_reg[`CBE_STAT_LAST_BIT]    <= taken_reg;
						reg_rdata_reg[`CBE_STAT_REFUSED_BIT] <= refused_sticky_reg;
					end
					`CBE_REG_TAKEN_CNT: reg_rdata_reg <= taken_cnt_reg;
					`CBE_REG_SKIP_CNT:  reg_rdata_reg <= skip_cnt_reg;
					default:            reg_rdata_reg <= `CBE_BYTE_ZERO;
				endcase
			end
		end
	end

	assign issue_ready  = issue_ready_reg;
	assign done         = done_reg;
	assign branch_taken = taken_reg;
	assign pc_next      = pc_next_reg;
	assign ccr_out      = ccr_out_reg;
	assign refused      = refused_reg;
	assign reg_rdata    = reg_rdata_reg;

	// ==========================================================
	// checks
	sequence s_issue;
		accept;
	endsequence

	// done rises on the third edge after the take and is seen one edge later
	sequence s_exec;
		##4 done_reg;
	endsequence

	sequence s_retire;
		retire;
	endsequence

	chk_three_cycles: assert property (
		@(posedge core_clk) disable iff (!reset_n || !clk_en)
		s_issue |-> s_exec)
		else $error("branch did not complete in three cycles");

	chk_taken_target: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		s_retire ##1 taken_reg |-> pc_next_reg ==
			PC_W'($past(pc_cap_reg, 1) + `CBE_INSTR_LEN
			+ {{(PC_W-8){$past(ofs_cap_reg[7], 1)}}, $past(ofs_cap_reg, 1)}))
		else $error("taken branch target wrong");

	chk_fall_through: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		s_retire ##1 !taken_reg |->
			pc_next_reg == PC_W'($past(pc_cap_reg, 1) + `CBE_INSTR_LEN))
		else $error("not-taken branch did not step by two");

	chk_flags_kept: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		s_retire |=> ccr_out_reg == $past(ccr_cap_reg))
		else $error("condition codes altered");

	chk_carry_set: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		retire && op_cap_reg == `CBE_OP_CARRY_SET |=>
			taken_reg == $past(ccr_cap_reg[`CBE_CCR_C]))
		else $error("carry-set outcome wrong");

	chk_equal_zero: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		retire && op_cap_reg == `CBE_OP_EQUAL |=>
			taken_reg == $past(ccr_cap_reg[`CBE_CCR_Z]))
		else $error("equal outcome wrong");

	chk_signed_ge: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		retire && op_cap_reg == `CBE_OP_SIGNED_GE |=> taken_reg ==
			!($past(ccr_cap_reg[`CBE_CCR_N]) ^ $past(ccr_cap_reg[`CBE_CCR_V])))
		else $error("signed greater-equal outcome wrong");

	chk_signed_gt: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		retire && op_cap_reg == `CBE_OP_SIGNED_GT |=> taken_reg ==
			!($past(ccr_cap_reg[`CBE_CCR_Z]) | ($past(ccr_cap_reg[`CBE_CCR_N])
			^ $past(ccr_cap_reg[`CBE_CCR_V]))))
		else $error("signed greater outcome wrong");

	chk_half_clear: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		retire && op_cap_reg == `CBE_OP_HALF_CLEAR |=>
			taken_reg == !$past(ccr_cap_reg[`CBE_CCR_H]))
		else $error("half-carry-clear outcome wrong");

	chk_half_set: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		retire && op_cap_reg == `CBE_OP_HALF_SET |=>
			taken_reg == $past(ccr_cap_reg[`CBE_CCR_H]))
		else $error("half-carry-set outcome wrong");

	chk_unsigned_hi: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		retire && op_cap_reg == `CBE_OP_UNSIGNED_HI |=> taken_reg ==
			!($past(ccr_cap_reg[`CBE_CCR_C]) | $past(ccr_cap_reg[`CBE_CCR_Z])))
		else $error("unsigned higher outcome wrong");

	chk_unsigned_hs: assert property (
		@(posedge core_clk) disable iff (!reset_n)
		retire && op_cap_reg == `CBE_OP_UNSIGNED_HS |=>
			taken_reg == !$past(ccr_cap_reg[`CBE_CCR_C]))
		else $error("unsigned higher-same outcome wrong");
endmodule

/* tb/cbe_fetch_model.sv */
`timescale 1ns/1ps

// ==========================================================
// fetch and sequencing stand-in: offers one branch, holds it until issue_ready is seen high
module cbe_fetch_model
	import cbe_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        go,
	input  wire logic [3:0]  lag,
	input  wire cbe_byte_t   op,
	input  wire cbe_byte_t   ofs,
	input  wire logic [15:0] pc,
	input  wire cbe_byte_t   condition_code_register,
	input  wire logic        issue_ready,
	output logic             issue_valid,
	output cbe_byte_t        issue_opcode,
	output cbe_byte_t        issue_offset,
	output logic      [15:0] issue_pc,
	output cbe_byte_t        ccr_in,
	output logic             sent
);
	logic       pend_reg; // offer waiting out its lag
	logic [3:0] lag_reg;  // cycles left before the offer goes up

	// offer sequencer; a slow lag exercises late requests
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			issue_valid  <= 1'b0;
			issue_opcode <= 8'h00;
			issue_offset <= 8'h00;
			issue_pc     <= 16'h0000;
			ccr_in       <= 8'h00;
			sent         <= 1'b0;
			pend_reg     <= 1'b0;
			lag_reg      <= 4'h0;
		end else begin
			sent <= 1'b0;
			if (issue_valid && issue_ready) begin
				// released bus shows the inverse so stale values never match
				issue_valid  <= 1'b0;
				sent         <= 1'b1;
				issue_opcode <= ~issue_opcode;
				issue_offset <= ~issue_offset;
				issue_pc     <= ~issue_pc;
				ccr_in       <= ~ccr_in;
			end else if (go) begin
				pend_reg <= 1'b1;
				lag_reg  <= lag;
			end else if (pend_reg && lag_reg != 4'h0) begin
				lag_reg <= lag_reg - 4'h1;
			end else if (pend_reg) begin
				// whole unit goes up together in one cycle
				pend_reg     <= 1'b0;
				issue_valid  <= 1'b1;
				issue_opcode <= op;
				issue_offset <= ofs;
				issue_pc     <= pc;
				ccr_in       <= condition_code_register;
			end
		end
	end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "cbe_params.svh"

// ==========================================================
// self-checking bench for the branch unit
module testbench
	import cbe_pkg::*;
;
	logic        core_clk;     // 25 MHz
	logic        reset_n;      // async, active low
	logic        clk_en;       // held running
	logic        go;           // start pulse to the fetch model
	logic [3:0]  lag_r;        // fetch model delay
	cbe_byte_t   op_r;         // opcode to offer
	cbe_byte_t   ofs_r;        // offset to offer
	logic [15:0] pc_r;         // pc to offer
	cbe_byte_t   ccr_r;        // flags to offer
	logic        issue_valid;  // model outputs
	cbe_byte_t   issue_opcode;
	cbe_byte_t   issue_offset;
	logic [15:0] issue_pc;
	cbe_byte_t   ccr_in;
	logic        sent;
	logic        issue_ready;  // design outputs
	logic        done;
	logic        branch_taken;
	logic [15:0] pc_next;
	cbe_byte_t   ccr_out;
	logic        refused;
	logic [3:0]  reg_addr;     // register port
	cbe_byte_t   reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	cbe_byte_t   reg_rdata;
	int          error_cnt;
	int          total_checks;

	// opcode, flag and offset tables; flags hit every branch both ways
	localparam cbe_byte_t OPS [8] = '{`CBE_OP_CARRY_SET, `CBE_OP_EQUAL, `CBE_OP_SIGNED_GE,
		`CBE_OP_SIGNED_GT, `CBE_OP_HALF_CLEAR, `CBE_OP_HALF_SET, `CBE_OP_UNSIGNED_HI,
		`CBE_OP_UNSIGNED_HS};
	localparam cbe_byte_t FLAGS [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h80, 8'h84,
		8'h10, 8'h86};
	localparam cbe_byte_t OFFS [3] = '{8'hFE, 8'h80, 8'h7F};

	// ==========================================================
	// design and partner
	cbe_branch_unit #(.PC_W(16)) i_cbe_branch_unit (
		.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
		.issue_valid(issue_valid), .issue_opcode(issue_opcode),
		.issue_offset(issue_offset), .issue_pc(issue_pc), .ccr_in(ccr_in),
		.issue_ready(issue_ready), .done(done), .branch_taken(branch_taken),
		.pc_next(pc_next), .ccr_out(ccr_out), .refused(refused),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);
	cbe_fetch_model i_cbe_fetch_model (
		.core_clk(core_clk), .reset_n(reset_n), .go(go), .lag(lag_r), .op(op_r),
		.ofs(ofs_r), .pc(pc_r), .condition_code_register(ccr_r), .issue_ready(issue_ready),
		.issue_valid(issue_valid), .issue_opcode(issue_opcode),
		.issue_offset(issue_offset), .issue_pc(issue_pc), .ccr_in(ccr_in), .sent(sent)
	);

	// clock
	always #20 core_clk = ~core_clk;

	// ==========================================================
	// reference condition, written from the flag formulae
	function automatic logic cond_of(input cbe_byte_t op, input cbe_byte_t f);
		case (op)
			8'h25: return f[0];
			8'h27: return f[1];
			8'h90: return !(f[2] ^ f[7]);
			8'h92: return !(f[1] | (f[2] ^ f[7]));
			8'h28: return !f[4];
			8'h29: return f[4];
			8'h22: return !(f[0] | f[1]);
			8'h24: return !f[0];
			default: return 1'b0;
		endcase
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// compare of any value up to 16 bits
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask

	// a wait that ran out ends the run
	task automatic stall(input string name);
		error_cnt++;
		$display("Error %s expected handshake seen none", name);
		close_out();
	endtask

	task automatic reg_write(input logic [3:0] a, input cbe_byte_t d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic reg_expect(input logic [3:0] a, input cbe_byte_t e, input string n);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1;
		chk(n, {8'h00, e}, {8'h00, reg_rdata});
	endtask

	// one branch through the partner; ok low means a refusal is expected
	task automatic branch(input cbe_byte_t o, input cbe_byte_t f, input logic [15:0] p,
		input cbe_byte_t c, input logic [3:0] l, input logic ok, output logic tk);
		logic [15:0] ep;
		int          n;
		@(posedge core_clk);
		op_r  <= o;
		ofs_r <= f;
		pc_r  <= p;
		ccr_r <= c;
		lag_r <= l;
		go    <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		n = 0;
		#1;
		while (sent !== 1'b1) begin
			if (n == 40) stall("offer");
			@(posedge core_clk);
			#1;
			n++;
		end
		tk = ok ? cond_of(o, c) : 1'b0;
		if (!ok) begin
			chk("refused", 16'h0001, {15'h0000, refused});
			return;
		end
		ep = tk ? p + 16'h0002 + {{8{f[7]}}, f} : p + 16'h0002;
		chk("issue_ready", 16'h0000, {15'h0000, issue_ready});
		n = 0;
		while (done !== 1'b1) begin
			if (n == 8) stall("done");
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("cycles", 16'h0003, n[15:0]);
		chk("taken", {15'h0000, tk}, {15'h0000, branch_taken});
		chk("pc_next", ep, pc_next);
		chk("ccr_out", {8'h00, c}, {8'h00, ccr_out});
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		reg_expect(`CBE_REG_CTRL, 8'h01, "ctrl");
		reg_expect(`CBE_REG_STATUS, 8'h00, "status");
		reg_expect(`CBE_REG_TAKEN_CNT, 8'h00, "taken_cnt");
		reg_expect(`CBE_REG_SKIP_CNT, 8'h00, "skip_cnt");
		reg_write(4'hF, 8'hA5);
		reg_expect(4'hF, 8'h00, "unmapped");
		$display("test reset done");
	endtask

	// every opcode against every flag pattern, offsets at both ends, pc wrapping
	task automatic t_conds();
		logic tk;
		int   nt;
		int   ns;
		nt = 0;
		ns = 0;
		tk = 1'b0;
		reg_write(`CBE_REG_CTRL, 8'h03);
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 9; j++) begin
				branch(OPS[i], OFFS[j % 3], 16'hFFF0 + 16'(j), FLAGS[j], 4'h0, 1'b1, tk);
				if (tk) nt++;
				else ns++;
			end
		end
		reg_expect(`CBE_REG_TAKEN_CNT, nt[7:0], "taken_cnt");
		reg_expect(`CBE_REG_SKIP_CNT, ns[7:0], "skip_cnt");
		reg_expect(`CBE_REG_STATUS, {6'h00, tk, 1'b0}, "status");
		$display("test conditions done");
	endtask

	// disabled unit and foreign opcode refuse; slow partner still served
	task automatic t_refuse();
		logic tk;
		reg_write(`CBE_REG_CTRL, 8'h00);
		branch(`CBE_OP_EQUAL, 8'h10, 16'h0200, 8'h02, 4'h0, 1'b0, tk);
		reg_expect(`CBE_REG_STATUS, 8'h06, "status");
		reg_write(`CBE_REG_STATUS, 8'h04);
		reg_expect(`CBE_REG_STATUS, 8'h02, "status");
		reg_write(`CBE_REG_CTRL, 8'h01);
		branch(8'h20, 8'h10, 16'h0300, 8'h00, 4'h0, 1'b0, tk);
		branch(`CBE_OP_SIGNED_GT, 8'h80, 16'h0000, 8'h68, 4'h5, 1'b1, tk);
		branch(`CBE_OP_HALF_SET, 8'h7F, 16'hFF80, 8'hEF, 4'h0, 1'b1, tk);
		$display("test refusal done");
	endtask

	// ==========================================================
	// main sequence
	initial begin
		core_clk     = 1'b0;
		reset_n      = 1'b0;
		clk_en       = 1'b1;
		go           = 1'b0;
		lag_r        = 4'h0;
		op_r         = 8'h00;
		ofs_r        = 8'h00;
		pc_r         = 16'h0000;
		ccr_r        = 8'h00;
		reg_addr     = 4'h0;
		reg_wdata    = 8'h00;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		error_cnt    = 0;
		total_checks = 0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset();
		t_conds();
		t_refuse();
		close_out();
	end
endmodule
